//--- rtl/logic_and_branch_carry_exec.sv
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

// How it works
// [RL1] Literal AND: working reg AND 8-bit immediate into working reg, only N and Z change.
// [RL2] Literal AND decodes from upper byte 0000 1011, low byte is the immediate.
// [RL3] File AND: working reg AND file reg; d=0 writes working reg, d=1 file reg.
// [RL4] File AND decodes from 0001 01da, low byte is file address; only N, Z change.
// [RL5] Access bit 0 uses access bank; 1 uses bank select register for the bank.
// [RL6] Extended set, a=0 and address at most 95: indexed literal offset addressing.
// [RL7] Branch on carry: PC plus two plus twice signed offset when carry set; flags kept.
// [RL8] Each AND is one word, four phases: decode, read operand, process, write.
module logic_and_branch_carry_exec #(
	parameter int PC_W = 21
) (
	input wire logic clk_in, // Core clock
	input wire logic resetn_in, // Async reset, active low
	input wire logic ce_in, // Clock enable, freezes all state when low
	input wire logic hsel_in, // AHB select
	input wire logic [exec_pkg::BUS_W-1:0] haddr_in, // AHB address
	input wire logic [1:0] htrans_in, // AHB transfer type
	input wire logic hwrite_in, // AHB write
	input wire logic [2:0] hsize_in, // AHB size, words only
	input wire logic [exec_pkg::BUS_W-1:0] hwdata_in, // AHB write data
	input wire logic hready_in, // AHB bus ready
	output logic [exec_pkg::BUS_W-1:0] hrdata_out, // AHB read data
	output logic hreadyout_out, // AHB slave ready
	output logic hresp_out, // AHB response, always OKAY
	output logic busy_out // Instruction in progress
);
	import exec_pkg::*;

	// ***************************************
	// Functions
	// ***************************************
	// N and Z placed at their status positions
	function automatic logic [STAT_W-1:0] nz_bits(input logic [7:0] res);
		logic [STAT_W-1:0] v;
		v = '0;
		v[ST_N] = res[7];
		v[ST_Z] = (res == 8'h00);
		return v;
	endfunction : nz_bits
	localparam logic [STAT_W-1:0] NZ_MASK = (STAT_W'(1) << ST_N) | (STAT_W'(1) << ST_Z);
	// ***************************************
	// State
	// ***************************************
	logic wr_pend_ff, rd_pend_ff, ready_ff, busy_ff;
	logic [7:0] addr_ff;
	logic [BUS_W-1:0] rdata_ff;
	logic ext_en_ff;
	logic [INSTR_W-1:0] instr_ff;
	logic [7:0] w_ff, operand_ff, result_ff;
	logic [STAT_W-1:0] status_ff;
	logic [BANK_W-1:0] bank_ff;
	logic [ADDR_W-1:0] index_ff, maddr_ff, last_ff;
	logic [PC_W-1:0] pc_ff;
	state_t state_ff;
	logic [1:0] q_ff;
	dec_t dec_ff;
	logic [7:0] mem_ff [0:MEM_DEPTH-1];
	dec_t dec_now;
	function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] off);
		return pend & (a == off);
	endfunction : wr_hit
	// ***************************************
	// Bus decode
	// ***************************************
	wire logic addr_take = hsel_in & htrans_in[1] & hready_in & ready_ff;
	wire logic idle = (state_ff == S_IDLE);
	wire logic start = wr_hit(wr_pend_ff, addr_ff, OFF_INSTR) & idle;
	wire logic sw_w = wr_hit(wr_pend_ff, addr_ff, OFF_W) & idle;
	wire logic sw_stat = wr_hit(wr_pend_ff, addr_ff, OFF_STATUS) & idle;
	wire logic sw_bank = wr_hit(wr_pend_ff, addr_ff, OFF_BANK) & idle;
	wire logic sw_index = wr_hit(wr_pend_ff, addr_ff, OFF_INDEX) & idle;
	wire logic sw_pc = wr_hit(wr_pend_ff, addr_ff, OFF_PC) & idle;
	wire logic sw_ctrl = wr_hit(wr_pend_ff, addr_ff, OFF_CTRL) & idle;
	wire logic sw_maddr = wr_hit(wr_pend_ff, addr_ff, OFF_MADDR);
	wire logic sw_mdata = wr_hit(wr_pend_ff, addr_ff, OFF_MDATA) & idle;
	// Read mux, unmapped reads as zero
	wire logic [BUS_W-1:0] rd_mux =
		(addr_ff == OFF_CTRL) ? BUS_W'({~idle, ext_en_ff}) :
		(addr_ff == OFF_INSTR) ? BUS_W'(instr_ff) :
		(addr_ff == OFF_W) ? BUS_W'(w_ff) :
		(addr_ff == OFF_STATUS) ? BUS_W'(status_ff) :
		(addr_ff == OFF_BANK) ? BUS_W'(bank_ff) :
		(addr_ff == OFF_INDEX) ? BUS_W'(index_ff) :
		(addr_ff == OFF_PC) ? BUS_W'(pc_ff) :
		(addr_ff == OFF_MADDR) ? BUS_W'(maddr_ff) :
		(addr_ff == OFF_MDATA) ? BUS_W'(mem_ff[maddr_ff]) :
		(addr_ff == OFF_LAST) ? BUS_W'(last_ff) : '0;
	// Bus slave: writes zero-wait, reads one wait so a preceding write is seen
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			ready_ff <= 1'b1;
			addr_ff <= 8'h00;
			rdata_ff <= '0;
		end else if (ce_in) begin
			wr_pend_ff <= addr_take & hwrite_in;
			rd_pend_ff <= addr_take & ~hwrite_in;
			if (addr_take) begin
				addr_ff <= haddr_in[7:0];
			end
			if (addr_take & ~hwrite_in) begin
				ready_ff <= 1'b0;
			end else if (rd_pend_ff) begin
				ready_ff <= 1'b1;
				rdata_ff <= rd_mux;
			end
		end
	end

	// ***************************************
	// Decoder
	// ***************************************
	and_branch_decode u_decode (
		.instr_in(instr_ff),
		.ext_en_in(ext_en_ff),
		.bank_in(bank_ff),
		.index_in(index_ff),
		.dec_out(dec_now)
	);

	// ***************************************
	// Sequencer and datapath
	// ***************************************
	wire logic in_q1 = (state_ff == S_EXEC) & (q_ff == 2'h1);
	wire logic in_q2 = (state_ff == S_EXEC) & (q_ff == 2'h2);
	wire logic in_q4 = (state_ff == S_EXEC) & (q_ff == Q_LAST);
	wire logic is_and = (dec_ff.kind == K_ANDL) | (dec_ff.kind == K_ANDF);
	wire logic take_br = in_q4 & (dec_ff.kind == K_BR_CARRY) & status_ff[ST_C]; // RL7
	wire logic core_w = in_q4 & ((dec_ff.kind == K_ANDL) | ((dec_ff.kind == K_ANDF) & ~dec_ff.to_file)); // RL1 RL3
	wire logic core_f = in_q4 & (dec_ff.kind == K_ANDF) & dec_ff.to_file; // RL3
	wire logic [PC_W-1:0] br_off = {{(PC_W-9){dec_ff.lit[7]}}, dec_ff.lit, 1'b0};
	wire logic [PC_W-1:0] nxt_pc = pc_ff + PC_W'(PC_STEP) + (take_br ? br_off : '0); // RL7
	wire logic [STAT_W-1:0] nxt_status = (status_ff & ~NZ_MASK) | nz_bits(result_ff); // RL1 RL4
	wire logic [7:0] nxt_operand = (dec_ff.kind == K_ANDL) ? dec_ff.lit : mem_ff[dec_ff.addr];
	// Phase counter, taken branch adds four flush cycles; busy kept in its own flop for the pin
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_ff <= S_IDLE;
			q_ff <= 2'h0;
			busy_ff <= 1'b0;
		end else if (ce_in) begin
			case (state_ff)
				S_IDLE: begin
					if (start) begin
						state_ff <= S_EXEC; // RL8
						q_ff <= 2'h0;
						busy_ff <= 1'b1;
					end
				end
				S_EXEC: begin
					q_ff <= q_ff + 2'h1; // RL8
					if (q_ff == Q_LAST) begin
						state_ff <= take_br ? S_FLUSH : S_IDLE; // RL7
						busy_ff <= take_br;
					end
				end
				S_FLUSH: begin
					q_ff <= q_ff + 2'h1;
					if (q_ff == Q_LAST) begin
						state_ff <= S_IDLE;
						busy_ff <= 1'b0;
					end
				end
				default: begin
					state_ff <= S_IDLE;
					q_ff <= 2'h0;
					busy_ff <= 1'b0;
				end
			endcase
		end
	end

	// Decode latch, operand read, process
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			instr_ff <= '0;
			dec_ff <= '0;
			operand_ff <= 8'h00;
			result_ff <= 8'h00;
			last_ff <= '0;
		end else if (ce_in) begin
			if (start) begin
				instr_ff <= hwdata_in[INSTR_W-1:0];
			end
			if ((state_ff == S_EXEC) & (q_ff == 2'h0)) begin
				dec_ff <= dec_now; // RL8
				last_ff <= dec_now.addr;
			end
			if (in_q1) begin
				operand_ff <= nxt_operand; // RL1 RL3
			end
			if (in_q2) begin
				result_ff <= w_ff & operand_ff; // RL1 RL3
			end
		end
	end

	// Architectural registers, software writes only while idle
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			w_ff <= RST_W;
			status_ff <= RST_STATUS;
			pc_ff <= '0;
		end else if (ce_in) begin
			if (core_w) begin
				w_ff <= result_ff; // RL1 RL3
			end else if (sw_w) begin
				w_ff <= hwdata_in[7:0];
			end
			if (in_q4 & is_and) begin
				status_ff <= nxt_status; // RL4
			end else if (sw_stat) begin
				status_ff <= hwdata_in[STAT_W-1:0];
			end
			if (in_q4) begin
				pc_ff <= nxt_pc; // RL7
			end else if (sw_pc) begin
				pc_ff <= hwdata_in[PC_W-1:0];
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ext_en_ff <= 1'b0;
			bank_ff <= RST_BANK;
			index_ff <= RST_INDEX;
			maddr_ff <= '0;
		end else if (ce_in) begin
			if (sw_ctrl) ext_en_ff <= hwdata_in[CTRL_EXT_BIT];
			if (sw_bank) bank_ff <= hwdata_in[BANK_W-1:0];
			if (sw_index) index_ff <= hwdata_in[ADDR_W-1:0];
			if (sw_maddr) maddr_ff <= hwdata_in[ADDR_W-1:0];
		end
	end

	// Data memory; core and bus writes never overlap since bus needs idle
	wire logic mem_we = core_f | sw_mdata;
	wire logic [ADDR_W-1:0] mem_wa = core_f ? dec_ff.addr : maddr_ff;
	wire logic [7:0] mem_wd = core_f ? result_ff : hwdata_in[7:0];
	always_ff @(posedge clk_in) begin
		if (ce_in && mem_we) begin
			mem_ff[mem_wa] <= mem_wd; // RL3
		end
	end
	// Outputs straight from flops, response is a fixed OKAY
	assign hrdata_out = rdata_ff;
	assign hreadyout_out = ready_ff;
	assign hresp_out = 1'b0;
	assign busy_out = busy_ff;

	// ***************************************
	// Assertions
	// ***************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in || !ce_in);

	sequence s_exec_run;
		(state_ff == S_EXEC) [*4];
	endsequence
	sequence s_flush_run;
		(state_ff == S_FLUSH) [*4];
	endsequence
	wire logic [PC_W-1:0] chk_off = {{(PC_W-8){dec_ff.lit[7]}}, dec_ff.lit};
	a_andl_result: assert property (in_q4 && dec_ff.kind == K_ANDL |=> // RL1
		w_ff == ($past(w_ff) & $past(dec_ff.lit))) else $error("literal AND result wrong");
	a_andl_decode: assert property (instr_ff[15:8] == 8'h0b |-> dec_now.kind == K_ANDL) // RL2
		else $error("literal AND not decoded");
	a_andf_dest: assert property (core_f |=> w_ff == $past(w_ff) && // RL3
		mem_ff[$past(dec_ff.addr)] == ($past(w_ff) & $past(operand_ff))) else $error("file AND dest wrong");
	a_andf_flags: assert property (in_q4 && dec_ff.kind == K_ANDF |=> // RL4
		status_ff[ST_C] == $past(status_ff[ST_C]) && status_ff[ST_OV] == $past(status_ff[ST_OV]) &&
		status_ff[ST_DC] == $past(status_ff[ST_DC]) && status_ff[ST_Z] == ($past(result_ff) == 8'h00) &&
		status_ff[ST_N] == $past(result_ff[7])) else $error("file AND flags wrong");
	a_bank_sel: assert property (dec_now.kind == K_ANDF && instr_ff[8] |-> // RL5
		dec_now.addr == {bank_ff, instr_ff[7:0]}) else $error("banked address wrong");
	a_access_bank: assert property (dec_now.kind == K_ANDF && !instr_ff[8] && !ext_en_ff |-> // RL5
		dec_now.addr[7:0] == instr_ff[7:0] && dec_now.addr[11:8] == (instr_ff[7:0] >= 8'h60 ? 4'hf : 4'h0))
		else $error("access bank address wrong");
	a_indexed_mode: assert property (dec_now.kind == K_ANDF && !instr_ff[8] && ext_en_ff && instr_ff[7:0] < 8'h60 |-> // RL6
		dec_now.indexed && dec_now.addr == index_ff + {4'h0, instr_ff[7:0]}) else $error("indexed address wrong");
	a_branch_taken: assert property (in_q4 && dec_ff.kind == K_BR_CARRY && status_ff[ST_C] |=> // RL7
		pc_ff == $past(pc_ff) + PC_W'(2) + $past(chk_off) + $past(chk_off) && status_ff == $past(status_ff)
		##0 s_flush_run ##1 idle) else $error("taken branch wrong");
	a_branch_skip: assert property (in_q4 && dec_ff.kind == K_BR_CARRY && !status_ff[ST_C] |=> // RL7
		pc_ff == $past(pc_ff) + PC_W'(2) && idle) else $error("untaken branch wrong");
	a_exec_length: assert property (start |=> s_exec_run ##1 (state_ff != S_EXEC)) // RL8
		else $error("execute not four phases");

endmodule : logic_and_branch_carry_exec

`default_nettype wire

//--- pkg/exec_pkg.sv
package exec_pkg;

	// ***************************************
	// Widths
	// ***************************************
	localparam int BUS_W = 32;
	localparam int ADDR_W = 12;
	localparam int STAT_W = 5;
	localparam int INSTR_W = 16;
	localparam int BANK_W = 4;
	localparam int MEM_DEPTH = 4096;

	// ***************************************
	// Register byte offsets (low address byte)
	// ***************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_INSTR = 8'h04;
	localparam logic [7:0] OFF_W = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_BANK = 8'h10;
	localparam logic [7:0] OFF_INDEX = 8'h14;
	localparam logic [7:0] OFF_PC = 8'h18;
	localparam logic [7:0] OFF_MADDR = 8'h1c;
	localparam logic [7:0] OFF_MDATA = 8'h20;
	localparam logic [7:0] OFF_LAST = 8'h24;

	// ***************************************
	// Field positions
	// ***************************************
	localparam int CTRL_EXT_BIT = 0;
	localparam int CTRL_BUSY_BIT = 1;
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_OV = 3;
	localparam int ST_N = 4;

	// ***************************************
	// Opcodes and addressing constants
	// ***************************************
	localparam logic [7:0] OP_ANDL = 8'h0b;
	localparam logic [5:0] OP_ANDF = 6'h05;
	localparam logic [7:0] OP_BR_CARRY = 8'he2;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [7:0] ILO_MAX = 8'h5f;
	localparam logic [3:0] ACCESS_LO = 4'h0;
	localparam logic [3:0] ACCESS_HI = 4'hf;

	// ***************************************
	// Reset values and counts
	// ***************************************
	localparam logic [7:0] RST_W = 8'h00;
	localparam logic [STAT_W-1:0] RST_STATUS = 5'h00;
	localparam logic [BANK_W-1:0] RST_BANK = 4'h0;
	localparam logic [ADDR_W-1:0] RST_INDEX = 12'h000;
	localparam logic [1:0] Q_LAST = 2'h3;
	localparam int PC_STEP = 2;

	// ***************************************
	// Types
	// ***************************************
	typedef enum logic [1:0] {K_OTHER, K_ANDL, K_ANDF, K_BR_CARRY} kind_t;
	typedef enum logic [1:0] {S_IDLE, S_EXEC, S_FLUSH} state_t;

	typedef struct packed {
		kind_t kind;
		logic to_file;
		logic bank_a;
		logic indexed;
		logic [7:0] lit;
		logic [ADDR_W-1:0] addr;
	} dec_t;

endpackage : exec_pkg

//--- rtl/and_branch_decode.sv
`timescale 1ns/10ps
`default_nettype none

module and_branch_decode (
	input wire logic [exec_pkg::INSTR_W-1:0] instr_in, // Instruction word
	input wire logic ext_en_in, // Extended set enabled
	input wire logic [exec_pkg::BANK_W-1:0] bank_in, // Bank select register
	input wire logic [exec_pkg::ADDR_W-1:0] index_in, // Index base for literal offset
	output var exec_pkg::dec_t dec_out // Decoded fields
);
	import exec_pkg::*;

	// ***************************************
	// Field split
	// ***************************************
	wire logic [7:0] f_field = instr_in[7:0];
	wire logic a_bit = instr_in[8];
	wire logic d_bit = instr_in[9];

	// Opcode match
	wire logic is_andl = (instr_in[15:8] == OP_ANDL); // RL2
	wire logic is_andf = (instr_in[15:10] == OP_ANDF); // RL4
	wire logic is_br_carry = (instr_in[15:8] == OP_BR_CARRY); // RL7
	wire kind_t kind = is_andl ? K_ANDL : is_andf ? K_ANDF : is_br_carry ? K_BR_CARRY : K_OTHER;

	// ***************************************
	// Address forming
	// ***************************************
	// Indexed mode only for the low access window, never when banked
	wire logic indexed = (kind == K_ANDF) & ext_en_in & ~a_bit & (f_field <= ILO_MAX); // RL6
	wire logic [ADDR_W-1:0] idx_addr = index_in + {4'h0, f_field}; // RL6
	wire logic [ADDR_W-1:0] acc_addr = (f_field < ACCESS_SPLIT) ? {ACCESS_LO, f_field} : {ACCESS_HI, f_field}; // RL5
	wire logic [ADDR_W-1:0] bank_addr = {bank_in, f_field}; // RL5
	wire logic [ADDR_W-1:0] eff_addr = indexed ? idx_addr : (a_bit ? bank_addr : acc_addr); // RL5

	// Result, one driver for the whole struct
	assign dec_out = '{kind: kind, to_file: d_bit, bank_a: a_bit, // RL3
		indexed: indexed, lit: f_field, addr: eff_addr};

endmodule : and_branch_decode

`default_nettype wire

//--- sim/logic_and_branch_carry_exec_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module logic_and_branch_carry_exec_tb_top;
	import exec_pkg::*;

	// ****************
	// Bench signals
	// ****************
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic busy;
	int errors = 0;
	int cmp_count = 0;

	// Core under test; clock enable driven by the bench, size fixed to word
	logic_and_branch_carry_exec i_dut (
		.clk_in(clk),
		.resetn_in(resetn),
		.ce_in(ce),
		.hsel_in(hsel),
		.haddr_in(haddr),
		.htrans_in(htrans),
		.hwrite_in(hwrite),
		.hsize_in(3'h2),
		.hwdata_in(hwdata),
		.hready_in(hready),
		.hrdata_out(hrdata),
		.hreadyout_out(hready),
		.hresp_out(hresp),
		.busy_out(busy)
	);

	// 250 MHz core clock
	always #2 clk = ~clk;

	// ****************
	// Shared tasks
	// ****************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One single word transfer; the master never assumes a wait count
	task automatic bus_xfer(input logic is_wr, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= is_wr;
		haddr <= {24'h0, off};
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus_xfer

	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		logic [31:0] t;
		bus_xfer(1'b1, off, d, t);
	endtask : wr

	task automatic chk_rd(input logic [7:0] off, input logic [31:0] exp);
		logic [31:0] v;
		bus_xfer(1'b0, off, 32'h0, v);
		check(v, exp);
	endtask : chk_rd

	task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
		wr(OFF_MADDR, {20'h0, a});
		wr(OFF_MDATA, {24'h0, d});
	endtask : mem_wr

	task automatic chk_mem(input logic [11:0] a, input logic [7:0] d);
		wr(OFF_MADDR, {20'h0, a});
		chk_rd(OFF_MDATA, {24'h0, d});
	endtask : chk_mem

	task automatic setup(input logic [31:0] w, input logic [31:0] st);
		wr(OFF_W, w);
		wr(OFF_STATUS, st);
	endtask : setup

	// Counts busy cycles after the start edge; sampled 1 ns late so edge updates land
	task automatic wait_idle(input int exp);
		int n;
		n = 0;
		#1;
		while (busy === 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(32'(n), 32'(exp));
	endtask : wait_idle

	task automatic run(input logic [15:0] instr, input int cyc);
		wr(OFF_INSTR, {16'h0, instr});
		wait_idle(cyc);
	endtask : run

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		logic [7:0] offs [9] = '{OFF_CTRL, OFF_INSTR, OFF_W, OFF_STATUS, OFF_BANK, OFF_INDEX, OFF_PC, OFF_MADDR, OFF_LAST};
		foreach (offs[i]) chk_rd(offs[i], 32'h0);
		wr(8'h40, 32'hffffffff);
		chk_rd(8'h40, 32'h0);
		check({31'h0, hresp}, 32'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_literal();
		setup(32'ha3, 32'h0b);
		wr(OFF_PC, 32'h10);
		run(16'h0b5f, 4);
		chk_rd(OFF_W, 32'h03);
		chk_rd(OFF_STATUS, 32'h0b);
		chk_rd(OFF_PC, 32'h12);
		setup(32'hf0, 32'h0b);
		run(16'h0b0f, 4);
		chk_rd(OFF_W, 32'h00);
		chk_rd(OFF_STATUS, 32'h0f);
		setup(32'hff, 32'h00);
		run(16'h0b80, 4);
		chk_rd(OFF_W, 32'h80);
		chk_rd(OFF_STATUS, 32'h10);
		$display("test literal done");
	endtask : t_literal

	task automatic t_file();
		mem_wr(12'h010, 8'hc2);
		setup(32'h17, 32'h00);
		run(16'h1410, 4);
		chk_rd(OFF_W, 32'h02);
		chk_mem(12'h010, 8'hc2);
		chk_rd(OFF_STATUS, 32'h00);
		wr(OFF_BANK, 32'h3);
		mem_wr(12'h320, 8'hff);
		setup(32'h81, 32'h01);
		run(16'h1720, 4);
		chk_mem(12'h320, 8'h81);
		chk_rd(OFF_LAST, 32'h320);
		chk_rd(OFF_STATUS, 32'h11);
		mem_wr(12'hf80, 8'h0f);
		setup(32'hf0, 32'h10);
		run(16'h1680, 4);
		chk_mem(12'hf80, 8'h00);
		chk_rd(OFF_W, 32'hf0);
		chk_rd(OFF_STATUS, 32'h04);
		mem_wr(12'h05f, 8'h77);
		setup(32'hff, 32'h00);
		run(16'h145f, 4);
		chk_rd(OFF_LAST, 32'h05f);
		chk_rd(OFF_W, 32'h77);
		$display("test file done");
	endtask : t_file

	task automatic t_indexed();
		wr(OFF_CTRL, 32'h1);
		wr(OFF_INDEX, 32'h200);
		mem_wr(12'h25f, 8'h3c);
		setup(32'h0f, 32'h00);
		run(16'h145f, 4);
		chk_rd(OFF_W, 32'h0c);
		chk_rd(OFF_LAST, 32'h25f);
		mem_wr(12'hf60, 8'haa);
		setup(32'hff, 32'h00);
		run(16'h1460, 4);
		chk_rd(OFF_W, 32'haa);
		chk_rd(OFF_LAST, 32'hf60);
		wr(OFF_INDEX, 32'hfe0);
		setup(32'hff, 32'h00);
		run(16'h1430, 4);
		chk_rd(OFF_LAST, 32'h010);
		chk_rd(OFF_W, 32'hc2);
		wr(OFF_CTRL, 32'h0);
		chk_rd(OFF_CTRL, 32'h0);
		$display("test indexed done");
	endtask : t_indexed

	task automatic t_branch();
		setup(32'h00, 32'h1f);
		wr(OFF_PC, 32'h100);
		run(16'he2fe, 8);
		chk_rd(OFF_PC, 32'h0fe);
		chk_rd(OFF_STATUS, 32'h1f);
		run(16'he27f, 8);
		chk_rd(OFF_PC, 32'h1fe);
		run(16'he280, 8);
		chk_rd(OFF_PC, 32'h100);
		wr(OFF_STATUS, 32'h1e);
		run(16'he205, 4);
		chk_rd(OFF_PC, 32'h102);
		chk_rd(OFF_STATUS, 32'h1e);
		wr(OFF_STATUS, 32'h01);
		wr(OFF_PC, 32'h0);
		run(16'he280, 8);
		chk_rd(OFF_PC, 32'h1fff02);
		$display("test branch done");
	endtask : t_branch

	// Clock enable low must stall the running instruction; the late busy read proves the freeze
	task automatic t_hold();
		setup(32'h3c, 32'h00);
		wr(OFF_INSTR, 32'h0b0f);
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		chk_rd(OFF_CTRL, 32'h2);
		wait_idle(1);
		chk_rd(OFF_W, 32'h0c);
		$display("test clock hold done");
	endtask : t_hold

	// A write landing while busy must not disturb the running instruction
	task automatic t_busy_drop();
		setup(32'h0f, 32'h00);
		wr(OFF_PC, 32'h40);
		wr(OFF_INSTR, 32'h0bf0);
		wr(OFF_W, 32'h55);
		wait_idle(2);
		chk_rd(OFF_W, 32'h00);
		chk_rd(OFF_STATUS, 32'h04);
		run(16'hffff, 4);
		chk_rd(OFF_PC, 32'h44);
		chk_rd(OFF_W, 32'h00);
		$display("test busy drop done");
	endtask : t_busy_drop

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	// Main sequence, reset held for 8 cycles
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_literal();
		t_file();
		t_indexed();
		t_branch();
		t_busy_drop();
		t_hold();
		test_done();
	end

	// Watchdog at 25000 cycles, far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		errors++;
		test_done();
	end

endmodule : logic_and_branch_carry_exec_tb_top

`default_nettype wire
